// File: debug_serial_consts.svh
`ifndef DEBUG_SERIAL_CONSTS_SVH
`define DEBUG_SERIAL_CONSTS_SVH
// long-low threshold that marks a speed sync request, in serial clock cycles
`define SYNC_DETECT_CYCLES 10'h0080
// inactivity window between falling edges, in serial clock cycles
`define TIMEOUT_CYCLES 10'h0200
// quiet gap before the sync answer, in serial clock cycles
`define SYNC_DELAY_CYCLES 10'h0010
// low time of the sync answer pulse, in serial clock cycles
`define SYNC_LOW_CYCLES 10'h0080
// low time below which a bit reads as one, in serial clock cycles
`define BIT_ONE_CYCLES 10'h0040
// width of the cycle counters
`define CNT_W 10
`endif

// File: debug_serial_pkg.sv
package debug_serial_pkg;
    // link-level states of the receive supervisor
    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_low = 3'b001,
        st_high = 3'b011,
        st_sync_wait = 3'b010,
        st_sync_delay = 3'b110,
        st_sync_low = 3'b111,
        st_sync_pulse = 3'b101
    } link_state_e;
    // events reported to the command layer
    typedef struct packed {
        logic bit_valid;
        logic sync_seen;
        logic soft_reset;
    } link_event_s;
    // drive of the shared debug pin
    typedef struct packed {
        logic pin_out;
        logic pin_oe;
    } pin_drive_s;
endpackage : debug_serial_pkg

// File: debug_serial_timeout.sv
`timescale 1ns/10ps
`include "debug_serial_consts.svh"
// Summary of operation
// - low beyond 128 cycles means sync request
// - sync waits for rise with no timeout
// - early release accepts bit, awaits next edge
// - 512 cycles without edge discards command
// - unfetched read data dropped after 512
// - handshake on suspends timeout until acknowledge
// - acknowledge re-arms 512-cycle timeout
// - timeout active during partial command or read
// - after soft reset next edge starts anew
// - sync answer: wait, 16, low 128, pulse
// - handshake disabled out of reset
module debug_serial_timeout
    import debug_serial_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic debug_serial_pin_in,
    output logic debug_serial_pin_out,
    output logic debug_serial_pin_oe,
    input wire logic transfer_open,
    input wire logic read_pending,
    input wire logic ack_enable_cmd,
    input wire logic ack_disable_cmd,
    input wire logic ack_pulse,
    output logic bit_valid,
    output logic bit_value,
    output logic sync_seen,
    output logic soft_reset,
    output logic handshake_on,
    output logic timeout_suspended
);
    logic pin_level; // synchronised pin
    logic pin_prev; // previous synchronised level for edge detection
    logic fall; // falling edge of the synchronised pin
    logic rise; // rising edge of the synchronised pin
    link_state_e state;
    link_state_e next_state;
    logic [`CNT_W-1:0] phase_cnt; // low time, sync delay or sync low time
    logic [`CNT_W-1:0] next_phase_cnt;
    logic [`CNT_W-1:0] idle_cnt; // cycles since last falling edge
    logic [`CNT_W-1:0] next_idle_cnt;
    logic armed; // a transfer is open or a read is pending, and the timeout may fire
    logic next_armed;
    logic suspend; // waiting on acknowledge with handshake on
    logic next_suspend;
    logic acked; // acknowledge already given for the pending read
    logic next_acked;
    logic next_handshake_on;
    link_event_s ev;
    link_event_s next_ev;
    logic next_bit_value;
    pin_drive_s drive;
    pin_drive_s next_drive;

    // the pin follows the host's timing, so it is synchronised first
    pin_sync u_pin_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .pin_async(debug_serial_pin_in),
        .pin_level(pin_level)
    );

    // edges of the agreed pin level; pin_prev resets high so reset makes no edge
    assign fall = pin_prev & ~pin_level;
    assign rise = ~pin_prev & pin_level;
    // outputs unpacked from the registered carriers
    assign bit_valid = ev.bit_valid;
    assign sync_seen = ev.sync_seen;
    assign soft_reset = ev.soft_reset;
    assign debug_serial_pin_out = drive.pin_out;
    assign debug_serial_pin_oe = drive.pin_oe;
    assign timeout_suspended = suspend;

    // next values for the link sequencer, the timeout and the handshake mode
    always_comb begin
        next_state = state;
        next_phase_cnt = phase_cnt;
        next_idle_cnt = idle_cnt;
        next_armed = armed;
        next_suspend = suspend;
        next_acked = acked;
        next_handshake_on = handshake_on;
        next_ev = '0;
        next_bit_value = bit_value;
        next_drive = '0;
        // mode commands; disable wins if both arrive together
        if (ack_enable_cmd) begin
            next_handshake_on = 1'b1;
        end
        if (ack_disable_cmd) begin
            next_handshake_on = 1'b0;
        end
        // an acknowledge is remembered until the read is fetched or dropped,
        // otherwise the still-pending read would freeze the timeout again
        if (ack_pulse) begin
            next_acked = 1'b1;
        end
        if (!read_pending) begin
            next_acked = 1'b0;
        end
        // read waiting on acknowledge: freeze the timeout only with handshake on
        if (handshake_on && read_pending && !ack_pulse && !acked) begin
            next_suspend = 1'b1;
        end
        if (ack_pulse || !read_pending) begin
            next_suspend = 1'b0;
        end
        // armed follows the command layer: nothing outstanding, nothing to drop
        next_armed = transfer_open || read_pending;
        // inactivity counter, saturating at the expiry value
        if (fall) begin
            next_idle_cnt = '0;
        end else if (!suspend && idle_cnt != `TIMEOUT_CYCLES) begin
            next_idle_cnt = idle_cnt + 1'b1;
        end
        // the acknowledge restarts the window; placed after the count so it wins
        if (ack_pulse) begin
            next_idle_cnt = '0;
        end
        // link sequencer: bit timing, sync detection and the sync answer
        unique case (state)
            st_idle, st_high: begin
                if (fall) begin
                    next_state = st_low;
                    next_phase_cnt = '0;
                    next_armed = 1'b1;
                end else if (state == st_high && armed && !suspend
                             && idle_cnt == `TIMEOUT_CYCLES - 1'b1) begin
                    // expiry discards the command or unfetched read data only
                    next_ev.soft_reset = 1'b1;
                    next_armed = 1'b0;
                    next_suspend = 1'b0;
                    next_state = st_idle;
                end
            end
            st_low: begin
                if (rise) begin
                    next_ev.bit_valid = 1'b1;
                    // low time is phase_cnt plus one
                    next_bit_value = (phase_cnt < `BIT_ONE_CYCLES - 1'b1);
                    next_state = st_high;
                end else if (phase_cnt == `SYNC_DETECT_CYCLES) begin
                    // low longer than the threshold: sync, partial transfer dropped
                    next_ev.sync_seen = 1'b1;
                    next_ev.soft_reset = 1'b1;
                    next_armed = 1'b0;
                    next_suspend = 1'b0;
                    next_state = st_sync_wait;
                end else begin
                    next_phase_cnt = phase_cnt + 1'b1;
                end
            end
            st_sync_wait: begin
                // no timeout here: the pin may stay low forever
                next_idle_cnt = '0;
                if (rise) begin
                    next_phase_cnt = '0;
                    next_state = st_sync_delay;
                end
            end
            st_sync_delay: begin
                if (phase_cnt == `SYNC_DELAY_CYCLES - 1'b1) begin
                    next_phase_cnt = '0;
                    next_drive = '{pin_out: 1'b0, pin_oe: 1'b1};
                    next_state = st_sync_low;
                end else begin
                    next_phase_cnt = phase_cnt + 1'b1;
                end
            end
            st_sync_low: begin
                if (phase_cnt == `SYNC_LOW_CYCLES - 1'b1) begin
                    next_drive = '{pin_out: 1'b1, pin_oe: 1'b1};
                    next_state = st_sync_pulse;
                end else begin
                    next_drive = '{pin_out: 1'b0, pin_oe: 1'b1};
                    next_phase_cnt = phase_cnt + 1'b1;
                end
            end
            st_sync_pulse: begin
                // drive released this cycle; our own pulse is not a host edge
                next_state = st_idle;
            end
            default: begin
                next_state = st_idle;
            end
        endcase
    end

    // register every piece of state; handshake starts disabled
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= st_idle;
            phase_cnt <= '0;
            idle_cnt <= '0;
            armed <= 1'b0;
            suspend <= 1'b0;
            acked <= 1'b0;
            handshake_on <= 1'b0;
            ev <= '0;
            bit_value <= 1'b0;
            drive <= '0;
            pin_prev <= 1'b1;
        end else begin
            state <= next_state;
            phase_cnt <= next_phase_cnt;
            idle_cnt <= next_idle_cnt;
            armed <= next_armed;
            suspend <= next_suspend;
            acked <= next_acked;
            handshake_on <= next_handshake_on;
            ev <= next_ev;
            bit_value <= next_bit_value;
            drive <= next_drive;
            pin_prev <= pin_level;
        end
    end
endmodule : debug_serial_timeout

// File: debug_serial_timeout_props.sv
`timescale 1ns/10ps
// pin-level counters let the properties measure real cycle counts
module debug_serial_timeout_props (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic debug_serial_pin_in,
    input wire logic debug_serial_pin_out,
    input wire logic debug_serial_pin_oe,
    input wire logic read_pending,
    input wire logic ack_enable_cmd,
    input wire logic ack_disable_cmd,
    input wire logic ack_pulse,
    input wire logic sync_seen,
    input wire logic soft_reset,
    input wire logic handshake_on,
    input wire logic timeout_suspended
);
    logic [15:0] low_len; // length of the current low on the wire
    logic [15:0] quiet; // cycles since the last falling edge
    logic [7:0] drv_low; // cycles the device has pulled the wire low
    // no reset needed: low_len and drv_low are forced by the idle wire levels, quiet by the first falling edge
    always_ff @(posedge ref_clk) begin
        low_len <= debug_serial_pin_in ? '0 : low_len + 16'h0001;
        quiet <= $fell(debug_serial_pin_in) ? '0 : quiet + 16'h0001;
        drv_low <= (debug_serial_pin_oe && !debug_serial_pin_out) ? drv_low + 8'h01 : '0;
    end
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    // synchroniser delay widens the window by a few cycles
    AST_SYNC_AT: assert property (sync_seen
        |-> low_len > 16'h0080 && low_len < 16'h008d) else $error("sync at wrong length");
    AST_SOFT_CAUSE: assert property (soft_reset
        |-> quiet > 16'h01ff || low_len > 16'h0080) else $error("early soft reset");
    AST_HELD: assert property (timeout_suspended && debug_serial_pin_in
        |-> !soft_reset) else $error("drop while suspended");
    AST_SUSP: assert property ($rose(read_pending) && handshake_on
        |-> ##[1:2] timeout_suspended) else $error("timeout not suspended");
    AST_REARM: assert property (ack_pulse
        |-> ##[1:2] !timeout_suspended) else $error("timeout not rearmed");
    AST_HS_ON: assert property (ack_enable_cmd && !ack_disable_cmd
        |=> handshake_on) else $error("handshake not enabled");
    AST_ANS_LOW: assert property ($rose(debug_serial_pin_out) && debug_serial_pin_oe
        |-> drv_low == 8'h80) else $error("answer low time wrong");
    AST_ANS_END: assert property (debug_serial_pin_oe && debug_serial_pin_out
        |=> !debug_serial_pin_oe) else $error("answer pulse too long");
    cover property (sync_seen);
    cover property (soft_reset);
    cover property (ack_pulse && timeout_suspended);
endmodule : debug_serial_timeout_props

// File: debug_serial_timeout_tb_top.sv
`timescale 1ns/10ps
module debug_serial_timeout_tb_top;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic transfer_open = 1'b0;
    logic read_pending = 1'b0;
    logic ack_enable_cmd = 1'b0;
    logic ack_disable_cmd = 1'b0;
    logic ack_pulse = 1'b0;
    logic debug_serial_pin_in, debug_serial_pin_out, debug_serial_pin_oe;
    logic bit_valid, bit_value, sync_seen, soft_reset, handshake_on, timeout_suspended;
    int bad_count = 0, checks_done = 0, n_soft = 0, n_sync = 0, drv_len = 0, last_low = 0;
    bit exp_q[$]; // model: expected value of each accepted bit
    always #5 ref_clk = ~ref_clk;
    debug_serial_timeout debug_serial_timeout_inst (.*);
    host_pod host_pod_inst (.*);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : check
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle
    task automatic pulse(ref logic s);
        s = 1'b1;
        idle(1);
        s = 1'b0;
    endtask : pulse
    // short lows read as one, long lows as zero
    task automatic send_bit(input int len);
        exp_q.push_back(len < 64);
        host_pod_inst.drive_low(len);
        idle(8);
    endtask : send_bit
    task automatic close_out();
        if (bad_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    // sample mid-cycle so the design's edge updates have settled
    always @(negedge ref_clk) begin
        if (bit_valid === 1'b1) check("bit_value", bit_value, exp_q.pop_front());
        n_soft += (soft_reset === 1'b1);
        n_sync += (sync_seen === 1'b1);
        if (debug_serial_pin_oe === 1'b1 && debug_serial_pin_out === 1'b0) drv_len++;
        else if (drv_len > 0) last_low = drv_len;
        if (debug_serial_pin_oe !== 1'b1) drv_len = 0;
    end
    initial begin
        int lens[4] = '{2, 63, 64, 128};
        void'($urandom(3188));
        idle(8);
        reset_n = 1'b1;
        check("handshake", handshake_on, 0);
        transfer_open = 1'b1;
        foreach (lens[i]) send_bit(lens[i]);
        repeat (12) send_bit($urandom_range(127, 2));
        idle(600);
        check("timeout", n_soft, 1);
        send_bit(40);
        transfer_open = 1'b0;
        idle(600);
        check("closed", n_soft, 1);
        host_pod_inst.drive_low(700);
        idle(200);
        check("sync", n_sync, 1);
        check("answer", last_low, 128);
        transfer_open = 1'b1;
        pulse(ack_enable_cmd);
        check("handshake", handshake_on, 1);
        send_bit(30);
        read_pending = 1'b1;
        idle(800);
        check("held", n_soft, 2);
        check("suspended", timeout_suspended, 1);
        pulse(ack_pulse);
        idle(600);
        check("rearm", n_soft, 3);
        check("released", timeout_suspended, 0);
        read_pending = 1'b0;
        pulse(ack_disable_cmd);
        send_bit(30);
        read_pending = 1'b1;
        idle(600);
        check("unfetched", n_soft, 4);
        check("no_hold", timeout_suspended, 0);
        check("bits", exp_q.size(), 0);
        close_out();
    end
    // cut a hang short well beyond the expected run
    initial begin
        #100_000;
        bad_count++;
        close_out();
    end
endmodule : debug_serial_timeout_tb_top
bind debug_serial_timeout debug_serial_timeout_props debug_serial_timeout_props_inst (
    .ref_clk, .reset_n, .debug_serial_pin_in, .debug_serial_pin_out, .debug_serial_pin_oe,
    .read_pending, .ack_enable_cmd, .ack_disable_cmd, .ack_pulse, .sync_seen, .soft_reset,
    .handshake_on, .timeout_suspended);

// File: host_pod.sv
`timescale 1ns/10ps
// host end of the single-wire link: open drain with a pull-up
module host_pod (
    input wire logic ref_clk,
    input wire logic debug_serial_pin_out,
    input wire logic debug_serial_pin_oe,
    output logic debug_serial_pin_in
);
    logic host_low = 1'b0; // host pulls the wire low
    // wired-and of both parties; a released wire floats high
    assign debug_serial_pin_in = !host_low && !(debug_serial_pin_oe && !debug_serial_pin_out);
    // every transfer opens with a host falling edge, held n cycles
    task automatic drive_low(input int n);
        @(posedge ref_clk);
        #1 host_low = 1'b1;
        repeat (n) @(posedge ref_clk);
        #1 host_low = 1'b0;
    endtask : drive_low
endmodule : host_pod

// File: pin_sync.sv
`timescale 1ns/10ps
// three-stage input synchroniser: the level changes once stages two and three agree
module pin_sync (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic pin_async,
    output logic pin_level
);
    logic [2:0] stage; // stage[0] is read only by stage[1]
    logic [2:0] next_stage;
    logic next_pin_level;

    // shift and accept only agreed values
    always_comb begin
        next_stage = {stage[1:0], pin_async};
        next_pin_level = (stage[2] == stage[1]) ? stage[1] : pin_level;
    end

    // idle line is high, so reset to one
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage <= 3'h7;
            pin_level <= 1'b1;
        end else begin
            stage <= next_stage;
            pin_level <= next_pin_level;
        end
    end
endmodule : pin_sync
